/* inc/acm_map.svh */
// register map, bit positions and port addresses of the attribute mapper
`ifndef ACM_MAP_SVH
`define ACM_MAP_SVH

`define ACM_PORT_ADDR_WR    16'h03c0
`define ACM_PORT_DATA_RD    16'h03c1
`define ACM_PORT_STAT_MONO  16'h03ba
`define ACM_PORT_STAT_COLOR 16'h03da

`define ACM_IDX_PAL_LAST    5'h0f
`define ACM_IDX_MODE        5'h10
`define ACM_IDX_BORDER      5'h11
`define ACM_IDX_PLANE       5'h12
`define ACM_IDX_PAN         5'h13
`define ACM_IDX_CSEL        5'h14

`define ACM_IDXREG_SRC_BIT  5
`define ACM_IDXREG_PTR_W    5

`define ACM_MODE_UPSEL_BIT  7
`define ACM_MODE_PWIDTH_BIT 6
`define ACM_MODE_PANCMP_BIT 5
`define ACM_MODE_BLINK_BIT  3
`define ACM_MODE_LGFX_BIT   2
`define ACM_MODE_MONO_BIT   1
`define ACM_MODE_GFX_BIT    0
`define ACM_MODE_RW_MASK    8'hef

`define ACM_PAL_W           6
`define ACM_PAL_DEPTH       16
`define ACM_PLANE_RW_MASK   8'h3f
`define ACM_PAN_RW_MASK     8'h0f
`define ACM_CSEL_RW_MASK    8'h0f

`define ACM_LGFX_FIRST      8'hc0
`define ACM_LGFX_LAST       8'hdf
`define ACM_PAN_NINE_WRAP   4'h8
`define ACM_PAN_MAX_CODE    4'h7

`endif

/* inc/acm_pkg.sv */
// types shared by the attribute mapper modules
package acm_pkg;

	typedef enum logic {
		ACM_SEL_INDEX,
		ACM_SEL_DATA
	} acm_flip_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] attr;
		logic [7:0] char_code;
		logic       fg_dot;
		logic       prev_dot;
		logic       ninth_col;
		logic       border;
	} acm_pixel_t;

	typedef struct packed {
		logic upper_color_source_sel;
		logic pixel_width_sel;
		logic pan_split_compat;
		logic reserved4;
		logic blink_enable;
		logic line_gfx_enable;
		logic mono_emulation;
		logic all_points_graphics;
	} acm_mode_t;

endpackage : acm_pkg

/* design/acm_pan_shift.sv */
// horizontal pan amount with split-screen reset
`timescale 1ns/1ps

`include "acm_map.svh"

module acm_pan_shift (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic [3:0] pan_value,
	input  wire logic       nine_dot,
	input  wire logic       pixel_width_sel,
	input  wire logic       pan_split_compat,
	input  wire logic       line_compare_hit,
	input  wire logic       vsync,
	output logic      [3:0] pan_amount
);

	logic       pan_forced_reg;
	logic [3:0] shift_next;

	// RL12 split forces zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pan_forced_reg <= 1'b0;
		end else if (pan_split_compat && line_compare_hit) begin
			pan_forced_reg <= 1'b1;
		end else if (vsync || !pan_split_compat) begin
			pan_forced_reg <= 1'b0;
		end
	end

	// RL22 shift per value
	always_comb begin
		shift_next = 4'h0;
		if (pixel_width_sel) begin
			if (pan_value <= `ACM_PAN_MAX_CODE) begin
				shift_next = {1'b0, pan_value[3:1]};
			end
		end else if (nine_dot) begin
			if (pan_value <= `ACM_PAN_MAX_CODE) begin
				shift_next = pan_value + 4'h1;
			end else if (pan_value == `ACM_PAN_NINE_WRAP) begin
				shift_next = 4'h0;
			end
		end else if (pan_value <= `ACM_PAN_MAX_CODE) begin
			shift_next = pan_value;
		end
	end

	// RL21 registered amount
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pan_amount <= 4'h0;
		end else if (pan_forced_reg) begin
			pan_amount <= 4'h0;
		end else begin
			pan_amount <= shift_next;
		end
	end

endmodule : acm_pan_shift

/* design/acm_attr_mapper.sv */
// attribute colour mapper: host port, palette and pixel path
// Functional notes
// RL1: source bit 0 gives host palette access
// RL2: source bit 1 lets pixels address palette
// RL3: index low five bits select data register
// RL4: internal toggle picks index or data
// RL5: status port read clears the toggle
// RL6: each shared port write flips toggle
// RL7: data read-back leaves toggle unchanged
// RL8: sixteen six-bit entries map colour out
// RL9: host changes palette in vertical retrace
// RL10: mode bit 7 picks upper colour source
// RL11: pixel width bit passes full 8-bit
// RL12: split match zeroes pan until vsync
// RL13: mode bit 3 blink or intensity
// RL14: ninth dot copies eighth for line graphics
// RL15: mode bit 1 selects mono emulation
// RL16: mode bit 0 selects text or graphics
// RL17: border register colours border area
// RL18: border one column, not narrow modes (code still shows it in narrow mode when mode bit 6 is set)
// RL19: plane enable bits gate colour planes
// RL20: plane bits 5:4 choose status pair
// RL21: four-bit pan register shifts left
// RL22: pan value to pixel shift table
// RL23: written on shared port, read separately
// RL24: colour select bits 3:2 top colour
// RL25: host disables interrupts around access
// RL26: reset to index state, reserved read zero
`timescale 1ns/1ps

`include "acm_map.svh"

module acm_attr_mapper #(
	parameter int PAL_DEPTH = `ACM_PAL_DEPTH,
	parameter int PAL_W     = `ACM_PAL_W
) (
	input  wire logic               clock,
	input  wire logic               reset_n,
	input  wire logic [15:0]        io_addr,
	input  wire logic               io_wr,
	input  wire logic               io_read_cycle,
	input  wire logic [7:0]         io_wdata,
	output logic      [7:0]         io_rdata,
	input  wire acm_pkg::acm_pixel_t pix_in,
	input  wire logic               blink_phase,
	input  wire logic               narrow_mode,
	input  wire logic               nine_dot,
	input  wire logic               line_compare_hit,
	input  wire logic               vsync,
	output logic      [7:0]         dac_color,
	output logic                    dac_valid,
	output logic      [1:0]         status_color_mux,
	output logic      [3:0]         pan_amount,
	output logic                    mono_emulation,
	output logic                    all_points_graphics,
	output logic                    index_selected
);

	acm_pkg::acm_flip_t flip_reg;
	logic [7:0]         index_reg;
	logic [PAL_W-1:0]   palette_entries [PAL_DEPTH];
	acm_pkg::acm_mode_t attr_mode_control;
	logic [7:0]         border_color;
	logic [7:0]         plane_enable;
	logic [7:0]         horizontal_pan;
	logic [7:0]         color_select;

	logic               wr_shared;
	logic               rd_index;
	logic               rd_data;
	logic               rd_status;
	logic               wr_data;
	logic [4:0]         ptr;
	logic               idx_phase;
	logic               pal_source;
	logic [7:0]         rdata_next;
	logic [3:0]         text_idx;
	logic [3:0]         pal_idx;
	logic [7:0]         color_next;
	logic [7:0]         dac_color_reg;
	logic               dac_valid_reg;
	logic [1:0]         status_reg;
	logic [7:0]         io_rdata_reg;
	logic               show_border;
	logic               is_lgfx;
	logic               dot;
	logic [3:0]         fg_nib;
	logic [3:0]         bg_nib;

	function automatic logic [7:0] assemble(
		input logic [PAL_W-1:0] entry,
		input logic [7:0]       csel,
		input logic             upsel
	);
		logic [7:0] result;
		result = {csel[3:2], entry[5:4], entry[3:0]};
		if (upsel) begin
			result[5:4] = csel[1:0];
		end
		return result;
	endfunction : assemble

	// exact match of a host port address
	function automatic logic port_hit(
		input logic [15:0] addr,
		input logic [15:0] port
	);
		return addr == port;
	endfunction : port_hit

	// pointer inside the palette window
	function automatic logic in_palette(
		input logic [4:0] p
	);
		return p <= `ACM_IDX_PAL_LAST;
	endfunction : in_palette

	// keep only the implemented bits of a data write
	function automatic logic [7:0] masked(
		input logic [7:0] data,
		input logic [7:0] mask
	);
		return data & mask;
	endfunction : masked

	// toggle state after a shared port write
	function automatic acm_pkg::acm_flip_t flip_next(
		input acm_pkg::acm_flip_t cur
	);
		return (cur == acm_pkg::ACM_SEL_INDEX) ?
			acm_pkg::ACM_SEL_DATA : acm_pkg::ACM_SEL_INDEX;
	endfunction : flip_next

	assign wr_shared = io_wr && port_hit(io_addr, `ACM_PORT_ADDR_WR);
	assign rd_index  = io_read_cycle && port_hit(io_addr, `ACM_PORT_ADDR_WR);
	assign rd_data   = io_read_cycle && port_hit(io_addr, `ACM_PORT_DATA_RD);
	assign rd_status = io_read_cycle &&
		(port_hit(io_addr, `ACM_PORT_STAT_MONO) ||
		 port_hit(io_addr, `ACM_PORT_STAT_COLOR));
	assign idx_phase = (flip_reg == acm_pkg::ACM_SEL_INDEX);
	assign wr_data   = wr_shared && !idx_phase;
	// RL3 pointer field
	assign ptr        = index_reg[`ACM_IDXREG_PTR_W-1:0];
	assign pal_source = index_reg[`ACM_IDXREG_SRC_BIT];

	// RL4 internal flip-flop
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			// RL26 reset to index
			flip_reg <= acm_pkg::ACM_SEL_INDEX;
		end else if (rd_status) begin
			// RL5 status read clears
			flip_reg <= acm_pkg::ACM_SEL_INDEX;
		end else if (wr_shared) begin
			// RL6 toggle every write
			flip_reg <= flip_next(flip_reg);
		end
		// RL7 data reads do not toggle
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			index_reg <= 8'h00;
		end else if (wr_shared && idx_phase) begin
			// RL26 reserved bits held zero
			index_reg <= {2'b00, io_wdata[5:0]};
		end
	end

	// RL1 host loads palette
	always_ff @(posedge clock) begin
		if (wr_data && in_palette(ptr)) begin
			palette_entries[ptr[3:0]] <= io_wdata[PAL_W-1:0];
		end
	end

	// RL23 shared port writes
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			attr_mode_control <= '0;
			border_color      <= 8'h00;
			plane_enable      <= 8'h00;
			horizontal_pan    <= 8'h00;
			color_select      <= 8'h00;
		end else if (wr_data) begin
			case (ptr)
				`ACM_IDX_MODE: begin
					attr_mode_control <= masked(io_wdata, `ACM_MODE_RW_MASK);
				end
				`ACM_IDX_BORDER: begin
					border_color <= io_wdata;
				end
				`ACM_IDX_PLANE: begin
					plane_enable <= masked(io_wdata, `ACM_PLANE_RW_MASK);
				end
				`ACM_IDX_PAN: begin
					horizontal_pan <= masked(io_wdata, `ACM_PAN_RW_MASK);
				end
				`ACM_IDX_CSEL: begin
					color_select <= masked(io_wdata, `ACM_CSEL_RW_MASK);
				end
				default: begin
				end
			endcase
		end
	end

	// RL23 read-back mux
	always_comb begin
		rdata_next = 8'h00;
		if (rd_index) begin
			rdata_next = index_reg;
		end else if (rd_data) begin
			if (in_palette(ptr)) begin
				rdata_next = {2'b00, palette_entries[ptr[3:0]]};
			end else begin
				case (ptr)
					`ACM_IDX_MODE:   rdata_next = attr_mode_control;
					`ACM_IDX_BORDER: rdata_next = border_color;
					`ACM_IDX_PLANE:  rdata_next = plane_enable;
					`ACM_IDX_PAN:    rdata_next = horizontal_pan;
					`ACM_IDX_CSEL:   rdata_next = color_select;
					default:         rdata_next = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			io_rdata_reg <= 8'h00;
		end else if (rd_index || rd_data) begin
			io_rdata_reg <= rdata_next;
		end
	end

	// text attribute split with blink or intensity
	always_comb begin
		fg_nib = pix_in.attr[3:0];
		bg_nib = pix_in.attr[7:4];
		// RL13 top bit usage
		if (attr_mode_control.blink_enable) begin
			bg_nib[3] = 1'b0;
			if (pix_in.attr[7] && blink_phase) begin
				fg_nib = bg_nib;
			end
		end
	end

	// RL14 line graphics ninth dot
	assign is_lgfx = (pix_in.char_code >= `ACM_LGFX_FIRST) &&
		(pix_in.char_code <= `ACM_LGFX_LAST);

	always_comb begin
		dot = pix_in.fg_dot;
		if (pix_in.ninth_col) begin
			dot = (attr_mode_control.line_gfx_enable && is_lgfx) ?
				pix_in.prev_dot : 1'b0;
		end
	end

	// RL16 text or graphics source
	always_comb begin
		text_idx = dot ? fg_nib : bg_nib;
		if (attr_mode_control.all_points_graphics) begin
			text_idx = pix_in.attr[3:0];
			if (attr_mode_control.blink_enable && blink_phase) begin
				text_idx[3] = 1'b0;
			end
		end
		// RL19 plane gating
		pal_idx = text_idx & plane_enable[3:0];
	end

	// RL18 border band suppression
	assign show_border = pix_in.border &&
		(!narrow_mode || attr_mode_control.pixel_width_sel);

	always_comb begin
		color_next = 8'h00;
		if (pix_in.border) begin
			// RL17 border colour
			color_next = show_border ? border_color : 8'h00;
		end else if (!pal_source) begin
			// RL1 host owns palette
			color_next = border_color;
		end else if (attr_mode_control.pixel_width_sel) begin
			// RL11 full 8-bit pixel
			color_next = pix_in.attr;
		end else begin
			// RL2 RL8 RL10 RL24 palette path
			color_next = assemble(palette_entries[pal_idx], color_select,
				attr_mode_control.upper_color_source_sel);
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			dac_color_reg <= 8'h00;
			dac_valid_reg <= 1'b0;
		end else begin
			dac_valid_reg <= pix_in.valid;
			if (pix_in.valid) begin
				dac_color_reg <= color_next;
			end
		end
	end

	// RL20 status pair select
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			status_reg <= 2'b00;
		end else if (pix_in.valid) begin
			case (plane_enable[5:4])
				2'b00:   status_reg <= {color_next[2], color_next[0]};
				2'b01:   status_reg <= {color_next[5], color_next[4]};
				2'b10:   status_reg <= {color_next[3], color_next[1]};
				default: status_reg <= {color_next[7], color_next[6]};
			endcase
		end
	end

	// RL21 RL12 pan amount
	acm_pan_shift u_pan (
		.clock            (clock),
		.reset_n          (reset_n),
		.pan_value        (horizontal_pan[3:0]),
		.nine_dot         (nine_dot),
		.pixel_width_sel  (attr_mode_control.pixel_width_sel),
		.pan_split_compat (attr_mode_control.pan_split_compat),
		.line_compare_hit (line_compare_hit),
		.vsync            (vsync),
		.pan_amount       (pan_amount)
	);

	assign io_rdata            = io_rdata_reg;
	assign dac_color           = dac_color_reg;
	assign dac_valid           = dac_valid_reg;
	assign status_color_mux    = status_reg;
	// RL15 mono emulation flag
	assign mono_emulation      = attr_mode_control.mono_emulation;
	assign all_points_graphics = attr_mode_control.all_points_graphics;
	assign index_selected      = idx_phase;

endmodule : acm_attr_mapper

/* sim/acm_attr_mapper_properties.sv */
// assertions on the host port and pixel outputs of the attribute mapper
`timescale 1ns/1ps

`include "acm_map.svh"

module acm_attr_mapper_checker #(
	parameter int PAL_DEPTH = 16,
	parameter int PAL_W     = 6
) (
	input wire logic                clock,
	input wire logic                reset_n,
	input wire logic [15:0]         io_addr,
	input wire logic                io_wr,
	input wire logic                io_read_cycle,
	input wire logic [7:0]          io_rdata,
	input wire acm_pkg::acm_pixel_t pix_in,
	input wire logic [7:0]          dac_color,
	input wire logic                dac_valid,
	input wire logic [3:0]          pan_amount,
	input wire logic                index_selected
);
	logic stat_rd;
	logic port_rd;
	assign stat_rd = io_read_cycle && (io_addr == `ACM_PORT_STAT_MONO
		|| io_addr == `ACM_PORT_STAT_COLOR);
	assign port_rd = io_read_cycle && (io_addr == `ACM_PORT_ADDR_WR
		|| io_addr == `ACM_PORT_DATA_RD);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_reset_index: assert property ($rose(reset_n) |-> index_selected)
		else $error("toggle not in index state after reset");
	a_status_clear: assert property (stat_rd |=> index_selected)
		else $error("status read did not select index");
	a_write_toggle: assert property (io_wr && io_addr == `ACM_PORT_ADDR_WR
		&& !stat_rd |=> index_selected != $past(index_selected))
		else $error("shared port write did not toggle");
	a_readback_keep: assert property (io_read_cycle && !io_wr
		&& io_addr == `ACM_PORT_DATA_RD |=> $stable(index_selected))
		else $error("read-back changed toggle");
	a_rdata_hold: assert property (!port_rd |=> $stable(io_rdata))
		else $error("read data changed without a read");
	a_index_reserved: assert property (io_read_cycle
		&& io_addr == `ACM_PORT_ADDR_WR |=> io_rdata[7:6] == 2'b00)
		else $error("index reserved bits not zero");
	a_pan_limit: assert property (pan_amount <= `ACM_PAN_NINE_WRAP)
		else $error("pan amount above eight");
	a_pixel_answer: assert property (pix_in.valid |=> dac_valid)
		else $error("pixel not answered next cycle");
	a_color_stands: assert property (!pix_in.valid
		|=> $stable(dac_color) && !dac_valid)
		else $error("colour changed without pixel");
endmodule : acm_attr_mapper_checker

bind acm_attr_mapper acm_attr_mapper_checker #(.PAL_DEPTH(PAL_DEPTH),
	.PAL_W(PAL_W)) u_checker (.clock(clock), .reset_n(reset_n),
	.io_addr(io_addr), .io_wr(io_wr), .io_read_cycle(io_read_cycle),
	.io_rdata(io_rdata), .pix_in(pix_in), .dac_color(dac_color),
	.dac_valid(dac_valid), .pan_amount(pan_amount),
	.index_selected(index_selected));

/* sim/acm_host_model.sv */
// host processor model issuing i/o reads and writes
`timescale 1ns/1ps

`include "acm_map.svh"

module acm_host_model (
	input  wire logic [7:0]  io_rdata,
	input  wire logic        clock,
	output logic      [15:0] io_addr,
	output logic             io_wr,
	output logic             io_read_cycle,
	output logic      [7:0]  io_wdata
);
	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_read_cycle = 1'b0;
		io_wdata = 8'h00;
	end
	// one strobe cycle, then the bus is released to inverted values
	task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d);
		@(posedge clock);
		#1;
		io_addr = a;
		io_wr = w;
		io_read_cycle = !w;
		io_wdata = d;
		@(posedge clock);
		#1;
		io_wr = 1'b0;
		io_read_cycle = 1'b0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask : cyc
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		cyc(a, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		cyc(a, 1'b0, 8'h00);
		d = io_rdata;
	endtask : rd
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] s;
		rd(`ACM_PORT_STAT_COLOR, s);
		wr(`ACM_PORT_ADDR_WR, idx);
		wr(`ACM_PORT_ADDR_WR, d);
	endtask : reg_wr
	// reset toggle, index, then read back
	task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
		logic [7:0] s;
		rd(`ACM_PORT_STAT_MONO, s);
		wr(`ACM_PORT_ADDR_WR, idx);
		rd(`ACM_PORT_DATA_RD, d);
	endtask : reg_rd
endmodule : acm_host_model

/* sim/acm_attr_mapper_tb.sv */
// self-checking bench for the attribute colour mapper
`timescale 1ns/1ps

`include "acm_map.svh"

module acm_attr_mapper_tb;
	logic                clock;
	logic                reset_n;
	logic [15:0]         io_addr;
	logic                io_wr;
	logic                io_read_cycle;
	logic [7:0]          io_wdata;
	logic [7:0]          io_rdata;
	acm_pkg::acm_pixel_t pix_in;
	logic                blink_phase;
	logic                narrow_mode;
	logic                nine_dot;
	logic                line_compare_hit;
	logic                vsync;
	logic [7:0]          dac_color;
	logic                dac_valid;
	logic [1:0]          status_color_mux;
	logic [3:0]          pan_amount;
	logic                mono_emulation;
	logic                all_points_graphics;
	logic                index_selected;
	int                  mismatches;
	int                  n_checks;
	logic [7:0]          d;

	acm_attr_mapper dut (.clock(clock), .reset_n(reset_n), .io_addr(io_addr),
		.io_wr(io_wr), .io_read_cycle(io_read_cycle), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .pix_in(pix_in), .blink_phase(blink_phase),
		.narrow_mode(narrow_mode), .nine_dot(nine_dot),
		.line_compare_hit(line_compare_hit), .vsync(vsync),
		.dac_color(dac_color), .dac_valid(dac_valid),
		.status_color_mux(status_color_mux), .pan_amount(pan_amount),
		.mono_emulation(mono_emulation),
		.all_points_graphics(all_points_graphics),
		.index_selected(index_selected));
	acm_host_model u_host (.io_rdata(io_rdata), .clock(clock),
		.io_addr(io_addr), .io_wr(io_wr), .io_read_cycle(io_read_cycle),
		.io_wdata(io_wdata));

	always #50 clock = ~clock;

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	function automatic logic [5:0] pal(input int i);
		return 6'(i * 7 + 3);
	endfunction : pal

	// f is fg_dot, prev_dot, ninth_col, border
	task automatic pix(input logic [7:0] a, input logic [7:0] ch,
		input logic [3:0] f, input logic [7:0] e);
		@(posedge clock);
		#1;
		pix_in = {1'b1, a, ch, f};
		@(posedge clock);
		#1;
		pix_in = {1'b0, ~a, ~ch, ~f};
		chk("dac_color", e, dac_color);
		chk("dac_valid", 8'h01, {7'h00, dac_valid});
	endtask : pix

	task automatic t_toggle;
		for (int s = 0; s < 2; s++) begin
			u_host.wr(`ACM_PORT_ADDR_WR, 8'h31);
			u_host.rd(s ? `ACM_PORT_STAT_COLOR : `ACM_PORT_STAT_MONO, d);
			chk("idx_sel", 8'h01, {7'h00, index_selected});
		end
		u_host.wr(`ACM_PORT_ADDR_WR, 8'h31);
		chk("idx_sel", 8'h00, {7'h00, index_selected});
		u_host.rd(`ACM_PORT_DATA_RD, d);
		chk("idx_sel", 8'h00, {7'h00, index_selected});
		u_host.wr(`ACM_PORT_ADDR_WR, 8'h5a);
		chk("idx_sel", 8'h01, {7'h00, index_selected});
		u_host.rd(`ACM_PORT_ADDR_WR, d);
		chk("index", 8'h31, d);
		u_host.reg_rd(8'h31, d);
		chk("border", 8'h5a, d);
		@(posedge clock);
		#1;
		reset_n = 1'b0;
		repeat (2) @(posedge clock);
		#1;
		reset_n = 1'b1;
		chk("idx_sel", 8'h01, {7'h00, index_selected});
		u_host.reg_rd(8'h31, d);
		chk("border", 8'h00, d);
		$display("test toggle done");
	endtask : t_toggle

	task automatic t_regs;
		logic [7:0] ix [5] = '{8'h30, 8'h32, 8'h33, 8'h34, 8'h35};
		logic [7:0] ex [5] = '{8'hef, 8'h3f, 8'h0f, 8'h0f, 8'h00};
		for (int i = 0; i < 5; i++) begin
			u_host.reg_wr(ix[i], 8'hff);
			u_host.reg_rd(ix[i], d);
			chk("reg", ex[i], d);
		end
		chk("mode", 8'h03, {6'h00, mono_emulation, all_points_graphics});
		u_host.reg_wr(8'h30, 8'h00);
		chk("mode", 8'h00, {6'h00, mono_emulation, all_points_graphics});
		$display("test registers done");
	endtask : t_regs

	task automatic t_palette;
		vsync = 1'b1;
		for (int i = 0; i < 16; i++) u_host.reg_wr(8'(i), {2'b11, pal(i)});
		vsync = 1'b0;
		u_host.reg_rd(8'h05, d);
		chk("pal", {2'b00, pal(5)}, d);
		u_host.reg_wr(8'h11, 8'h77);
		u_host.reg_wr(8'h12, 8'h0f);
		u_host.reg_wr(8'h14, 8'h0b);
		u_host.reg_wr(8'h10, 8'h01);
		pix(8'h06, 8'h00, 4'h0, 8'h77);
		u_host.reg_wr(8'h30, 8'h01);
		for (int i = 0; i < 16; i++) pix(8'(i), 8'h00, 4'h0, {2'b10, pal(i)});
		u_host.reg_wr(8'h30, 8'h81);
		pix(8'h09, 8'h00, 4'h0, {4'hb, 4'(pal(9))});
		u_host.reg_wr(8'h32, 8'h03);
		pix(8'h0f, 8'h00, 4'h0, {4'hb, 4'(pal(3))});
		u_host.reg_wr(8'h30, 8'h41);
		for (int s = 0; s < 4; s++) begin
			u_host.reg_wr(8'h32, {2'b00, 2'(s), 4'hf});
			pix(8'h96, 8'h00, 4'h0, 8'h96);
			d = 8'h96;
			d = s == 0 ? {6'h00, d[2], d[0]} : s == 1 ? {6'h00, d[5], d[4]}
				: s == 2 ? {6'h00, d[3], d[1]} : {6'h00, d[7], d[6]};
			chk("status", d, {6'h00, status_color_mux});
		end
		$display("test palette done");
	endtask : t_palette

	task automatic t_text;
		logic [7:0] ch [4] = '{8'hc0, 8'hdf, 8'hbf, 8'he0};
		u_host.reg_wr(8'h32, 8'h0f);
		u_host.reg_wr(8'h30, 8'h00);
		pix(8'h9e, 8'h41, 4'h0, {2'b10, pal(9)});
		u_host.reg_wr(8'h30, 8'h08);
		pix(8'h9e, 8'h41, 4'h0, {2'b10, pal(1)});
		blink_phase = 1'b1;
		pix(8'h9e, 8'h41, 4'h8, {2'b10, pal(1)});
		u_host.reg_wr(8'h30, 8'h09);
		pix(8'h0f, 8'h00, 4'h0, {2'b10, pal(7)});
		blink_phase = 1'b0;
		u_host.reg_wr(8'h30, 8'h04);
		for (int i = 0; i < 4; i++) pix(8'h1e, ch[i], 4'h6, {2'b10, pal(i < 2 ? 14 : 1)});
		$display("test text done");
	endtask : t_text

	task automatic t_border;
		u_host.reg_wr(8'h30, 8'h01);
		pix(8'h03, 8'h00, 4'h1, 8'h77);
		narrow_mode = 1'b1;
		pix(8'h03, 8'h00, 4'h1, 8'h00);
		u_host.reg_wr(8'h30, 8'h41);
		pix(8'h03, 8'h00, 4'h1, 8'h77);
		narrow_mode = 1'b0;
		$display("test border done");
	endtask : t_border

	task automatic pulse(input logic hit);
		@(posedge clock);
		#1;
		if (hit) line_compare_hit = 1'b1; else vsync = 1'b1;
		@(posedge clock);
		#1;
		line_compare_hit = 1'b0;
		vsync = 1'b0;
		@(posedge clock);
		#1;
	endtask : pulse

	task automatic t_pan;
		logic [7:0] md [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h41, 8'h01};
		logic [3:0] v [6] = '{4'h5, 4'h5, 4'h8, 4'h0, 4'h6, 4'h7};
		logic [3:0] ex [6] = '{4'h5, 4'h6, 4'h0, 4'h1, 4'h3, 4'h7};
		for (int i = 0; i < 6; i++) begin
			nine_dot = i inside {[1:3]};
			u_host.reg_wr(8'h30, md[i]);
			u_host.reg_wr(8'h33, {4'h0, v[i]});
			@(posedge clock);
			#1;
			chk("pan", {4'h0, ex[i]}, {4'h0, pan_amount});
		end
		u_host.reg_wr(8'h30, 8'h21);
		u_host.reg_wr(8'h33, 8'h05);
		pulse(1'b1);
		chk("pan", 8'h00, {4'h0, pan_amount});
		pulse(1'b0);
		chk("pan", 8'h05, {4'h0, pan_amount});
		u_host.reg_wr(8'h30, 8'h01);
		pulse(1'b1);
		chk("pan", 8'h05, {4'h0, pan_amount});
		$display("test pan done");
	endtask : t_pan

	initial begin
		repeat (50000) @(posedge clock);
		mismatches++;
		end_sim();
	end

	initial begin
		clock = 1'b0;
		reset_n = 1'b0;
		pix_in = '0;
		blink_phase = 1'b0;
		narrow_mode = 1'b0;
		nine_dot = 1'b0;
		line_compare_hit = 1'b0;
		vsync = 1'b0;
		mismatches = 0;
		n_checks = 0;
		repeat (16) @(posedge clock);
		#1;
		reset_n = 1'b1;
		chk("idx_sel", 8'h01, {7'h00, index_selected});
		chk("dac_valid", 8'h00, {7'h00, dac_valid});
		$display("test reset done");
		t_toggle();
		t_regs();
		t_palette();
		t_text();
		t_border();
		t_pan();
		end_sim();
	end
endmodule : acm_attr_mapper_tb
